//--- rtl/apsc_regs.vh
`ifndef APSC_REGS_VH
`define APSC_REGS_VH
// =====================================================
// Clock and timing figures (ns unless noted)
`define APSC_CLK_NS 20
`define APSC_T_RC_NS 70
`define APSC_T_WP_NS 45
`define APSC_T_WR_NS 10
`define APSC_T_CP_NS 12
`define APSC_T_OHCL_NS 5
`define APSC_T_OEH_NS 12
`define APSC_T_EP_NS 70
`define APSC_T_EPS_NS 70
`define APSC_T_EPH_NS 70
`define APSC_T_EAS_NS 15
`define APSC_T_SET_NS 20
`define APSC_T_CHH_US 350
`define APSC_T_CHHN_US 1
// Least times round up to whole cycles
`define APSC_CYC(ns) (((ns) + `APSC_CLK_NS - 1) / `APSC_CLK_NS)
`define APSC_US_CYC(us) (((us) * 1000 + `APSC_CLK_NS - 1) / `APSC_CLK_NS)
// =====================================================
// Command codes
`define APSC_CMD_SRAM_RD 3'h0
`define APSC_CMD_SRAM_WR 3'h1
`define APSC_CMD_FC_RD 3'h2
`define APSC_CMD_FC_WR 3'h3
`define APSC_CMD_PD_ENTER 3'h4
`define APSC_CMD_PD_EXIT 3'h5
`define APSC_CMD_PD_PROG 3'h6
`define APSC_CNT_W 16
`endif

//--- rtl/apsc_wait_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "apsc_regs.vh"
// =====================================================
// Down counter: load a count, done when zero
module apsc_wait_timer (
    input wire mclk_in,
    input wire srst_in,
    input wire load_in,
    input wire [`APSC_CNT_W-1:0] count_in,
    output wire done_out
);
    reg [`APSC_CNT_W-1:0] cnt_ff; // Remaining cycles
    // Load wins over counting
    always @(posedge mclk_in) begin
        if (srst_in) begin
            cnt_ff <= {`APSC_CNT_W{1'b0}};
        end else if (load_in) begin
            cnt_ff <= count_in;
        end else if (cnt_ff != {`APSC_CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end
    // Zero means expired; gating by load would loop back through the caller's load logic
    assign done_out = (cnt_ff == {`APSC_CNT_W{1'b0}});
endmodule
`default_nettype wire

//--- rtl/apsc_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "apsc_regs.vh"
// How it works
// RL1: SRAM writes while select and strobe low
// RL2: Byte lanes: one for byte, both for word
// RL3: Write ends at earlier select/strobe rise
// RL4: Config low makes SRAM ignore byte lanes
// RL5: Config held high for lane-framed writes
// RL6: Late enable release starts an FCRAM read
// RL7: Then delay strobe one read cycle
// RL8: Write cycle covers pulse plus recovery
// RL9: Pulse limit follows the starting edge
// RL10: Select rises with strobe; keep select pulse
// RL11: Address changes only after write end
// RL12: Access stretches by any setup shortfall
// RL13: Shortened delays extend address hold
// RL14: Setup and enable-high keep absolute floors
// RL15: Page bits change gives new data
// RL16: Page bits never switch apart
// RL17: Enable stays high after strobe-ended write
// RL18: Select high 350 us or 1 us after exit
// RL19: Program: select high, enable pulse, setup
// RL20: Secondary and program enables high in writes
// RL21: Enables and strobe high in reads
// RL22: Release data bus when not writing
module apsc_ctrl #(
    parameter CHH_CYC = `APSC_US_CYC(`APSC_T_CHH_US),
    parameter CHHN_CYC = `APSC_US_CYC(`APSC_T_CHHN_US)
) (
    input wire mclk_in,
    input wire srst_in,
    // User request side
    input wire req_valid_in,
    output wire req_ready_out,
    input wire [2:0] req_cmd_in,
    input wire [21:0] req_addr_in,
    input wire [15:0] req_wdata_in,
    input wire [1:0] req_byte_en_in,
    input wire req_sleep_in,
    output reg rsp_valid_out,
    output reg [15:0] rsp_rdata_out,
    // Memory pins
    output reg [21:0] mem_addr_out,
    input wire [15:0] mem_data_in,
    output reg [15:0] mem_data_out,
    output reg mem_data_oe_out,
    output reg mem_we_n_out,
    output reg mem_oe_n_out,
    output reg upper_byte_lane_n_out,
    output reg lower_byte_lane_n_out,
    output reg byte_config_input_out,
    output reg sram_primary_select_n_out,
    output reg sram_secondary_select_out,
    output reg fcram_primary_select_n_out,
    output reg fcram_powerdown_enable_out,
    output reg program_enable_n_out
);
    // =====================================================
    // Phase timing in cycles
    localparam [15:0] C_SET = `APSC_CYC(`APSC_T_SET_NS);
    localparam [15:0] C_RC = `APSC_CYC(`APSC_T_RC_NS);
    localparam [15:0] C_WP = `APSC_CYC(`APSC_T_WP_NS);
    localparam [15:0] C_WR = `APSC_CYC(`APSC_T_WR_NS);
    localparam [15:0] C_CP = `APSC_CYC(`APSC_T_CP_NS);
    localparam [15:0] C_OHCL = `APSC_CYC(`APSC_T_OHCL_NS);
    localparam [15:0] C_EP = `APSC_CYC(`APSC_T_EP_NS);
    localparam [15:0] C_EPS = `APSC_CYC(`APSC_T_EPS_NS);
    localparam [15:0] C_EPH = `APSC_CYC(`APSC_T_EPH_NS);
    localparam [15:0] C_EAS = `APSC_CYC(`APSC_T_EAS_NS);
    localparam [15:0] C_CHH = CHH_CYC;
    localparam [15:0] C_CHHN = CHHN_CYC;
    // =====================================================
    // States
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_SETUP = 4'h1;
    localparam [3:0] S_ACCESS = 4'h2;
    localparam [3:0] S_STROBE = 4'h3;
    localparam [3:0] S_RECOV = 4'h4;
    localparam [3:0] S_GAP = 4'h5;
    localparam [3:0] S_PD = 4'h6;
    localparam [3:0] S_PD_HOLD = 4'h7;
    localparam [3:0] S_PG_SETUP = 4'h8;
    localparam [3:0] S_PG_PULSE = 4'h9;
    localparam [3:0] S_PG_HOLD = 4'hA;

    reg [3:0] state_ff; // Sequencer state
    reg [2:0] cmd_ff; // Latched command
    reg pd_ff; // Powered down flag
    reg [15:0] din_s1_ff; // Read data first stage
    reg [15:0] din_s2_ff; // Read data second stage
    reg ld; // Timer load strobe
    reg [15:0] ld_val; // Timer load value
    wire tdone; // Timer expired

    // Delay timer, one shared by every phase
    apsc_wait_timer u_timer (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .load_in(ld),
        .count_in(ld_val),
        .done_out(tdone)
    );

    // Decode: is this an FCRAM command
    function is_fc;
        input [2:0] c;
        begin
            is_fc = (c == `APSC_CMD_FC_RD) || (c == `APSC_CMD_FC_WR);
        end
    endfunction

    // Decode: is this a write command
    function is_wr;
        input [2:0] c;
        begin
            is_wr = (c == `APSC_CMD_SRAM_WR) || (c == `APSC_CMD_FC_WR);
        end
    endfunction

    // Only accept work when idle; in PD any request is taken as exit
    assign req_ready_out = (state_ff == S_IDLE) | ((state_ff == S_PD) & tdone);

    // =====================================================
    // Timer loads on phase entry
    always @* begin
        ld = 1'b0;
        ld_val = 16'h0000;
        case (state_ff)
            S_IDLE: begin
                if (req_valid_in) begin
                    ld = 1'b1;
                    // Long setup after enable rise: avoids a read start
                    ld_val = (req_cmd_in == `APSC_CMD_PD_PROG) ? C_EPS : C_SET; // RL6
                end
            end
            S_SETUP: begin
                if (tdone) begin
                    ld = 1'b1;
                    ld_val = is_wr(cmd_ff) ? C_WP : C_RC; // RL9
                end
            end
            S_ACCESS, S_STROBE: begin
                if (tdone) begin
                    ld = 1'b1;
                    ld_val = C_WR; // RL8
                end
            end
            S_RECOV: begin
                if (tdone) begin
                    ld = 1'b1;
                    ld_val = C_CP; // RL10
                end
            end
            S_PD: begin
                if (req_valid_in && tdone) begin
                    ld = 1'b1;
                    ld_val = req_sleep_in ? C_CHH : C_CHHN; // RL18
                end
            end
            S_PG_SETUP: begin
                if (tdone) begin
                    ld = 1'b1;
                    ld_val = C_EP; // RL19
                end
            end
            S_PG_PULSE: begin
                if (tdone) begin
                    ld = 1'b1;
                    ld_val = C_EPH;
                end
            end
            S_PD_HOLD: ld_val = 16'h0000;
            default: ld_val = 16'h0000;
        endcase
    end

    // =====================================================
    // Sequencer and pin drive
    always @(posedge mclk_in) begin
        if (srst_in) begin
            state_ff <= S_IDLE;
            cmd_ff <= 3'h0;
            pd_ff <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 16'h0000;
            mem_addr_out <= 22'h000000;
            mem_data_out <= 16'h0000;
            mem_data_oe_out <= 1'b0;
            mem_we_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            upper_byte_lane_n_out <= 1'b1;
            lower_byte_lane_n_out <= 1'b1;
            byte_config_input_out <= 1'b1;
            sram_primary_select_n_out <= 1'b1;
            sram_secondary_select_out <= 1'b1;
            fcram_primary_select_n_out <= 1'b1;
            fcram_powerdown_enable_out <= 1'b1;
            program_enable_n_out <= 1'b1;
        end else begin
            rsp_valid_out <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (req_valid_in) begin
                        cmd_ff <= req_cmd_in;
                        mem_addr_out <= req_addr_in; // RL16
                        mem_oe_n_out <= 1'b1; // RL6 RL7
                        program_enable_n_out <= 1'b1; // RL20
                        fcram_powerdown_enable_out <= 1'b1; // RL21
                        byte_config_input_out <= 1'b1; // RL5
                        if (req_cmd_in == `APSC_CMD_PD_ENTER) begin
                            // Select high then drop the power-down enable
                            fcram_powerdown_enable_out <= 1'b0;
                            pd_ff <= 1'b1;
                            state_ff <= S_PD;
                        end else if (req_cmd_in == `APSC_CMD_PD_PROG) begin
                            state_ff <= S_PG_SETUP; // RL19
                        end else if (req_cmd_in == `APSC_CMD_PD_EXIT) begin
                            rsp_valid_out <= 1'b1;
                        end else begin
                            mem_data_out <= req_wdata_in;
                            mem_data_oe_out <= is_wr(req_cmd_in); // RL22
                            // Each lane low only when asked; none means word
                            upper_byte_lane_n_out <= ~(req_byte_en_in[1] | ~|req_byte_en_in); // RL2
                            lower_byte_lane_n_out <= ~(req_byte_en_in[0] | ~|req_byte_en_in); // RL2
                            if (is_fc(req_cmd_in)) begin
                                fcram_primary_select_n_out <= 1'b0;
                            end else begin
                                sram_primary_select_n_out <= 1'b0; // RL1
                            end
                            state_ff <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    if (tdone) begin
                        if (is_wr(cmd_ff)) begin
                            mem_we_n_out <= 1'b0; // RL1
                            state_ff <= S_STROBE;
                        end else begin
                            mem_oe_n_out <= 1'b0; // RL14 RL21
                            state_ff <= S_ACCESS;
                        end
                    end
                end
                S_ACCESS: begin
                    // Full read cycle; sample at its end
                    if (tdone) begin
                        rsp_rdata_out <= din_s2_ff; // RL15
                        rsp_valid_out <= 1'b1;
                        mem_oe_n_out <= 1'b1;
                        state_ff <= S_RECOV; // RL13
                    end
                end
                S_STROBE: begin
                    // Strobe and select rise together; ends write
                    if (tdone) begin
                        mem_we_n_out <= 1'b1; // RL3 RL17
                        sram_primary_select_n_out <= 1'b1; // RL3
                        fcram_primary_select_n_out <= 1'b1; // RL10
                        state_ff <= S_RECOV;
                    end
                end
                S_RECOV: begin
                    // Address and data held through recovery
                    if (tdone) begin
                        if (is_wr(cmd_ff)) begin
                            rsp_valid_out <= 1'b1;
                        end
                        sram_primary_select_n_out <= 1'b1;
                        fcram_primary_select_n_out <= 1'b1;
                        mem_data_oe_out <= 1'b0; // RL22
                        upper_byte_lane_n_out <= 1'b1;
                        lower_byte_lane_n_out <= 1'b1;
                        state_ff <= S_GAP; // RL11
                    end
                end
                S_GAP: begin
                    // Select-high pulse before the next cycle
                    if (tdone) begin
                        state_ff <= S_IDLE; // RL10
                    end
                end
                S_PD: begin
                    if (req_valid_in && tdone) begin
                        fcram_powerdown_enable_out <= 1'b1; // RL18
                        state_ff <= S_PD_HOLD;
                    end
                end
                S_PD_HOLD: begin
                    // Select stays high for the exit hold
                    if (tdone) begin
                        pd_ff <= 1'b0;
                        rsp_valid_out <= 1'b1;
                        state_ff <= S_IDLE; // RL18
                    end
                end
                S_PG_SETUP: begin
                    if (tdone) begin
                        program_enable_n_out <= 1'b0; // RL19
                        state_ff <= S_PG_PULSE;
                    end
                end
                S_PG_PULSE: begin
                    // Address set since entry: covers setup to rise
                    if (tdone) begin
                        program_enable_n_out <= 1'b1; // RL19
                        state_ff <= S_PG_HOLD;
                    end
                end
                S_PG_HOLD: begin
                    if (tdone) begin
                        rsp_valid_out <= 1'b1;
                        state_ff <= S_IDLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // =====================================================
    // Read data synchroniser, pins are asynchronous
    always @(posedge mclk_in) begin
        if (srst_in) begin
            din_s1_ff <= 16'h0000;
            din_s2_ff <= 16'h0000;
        end else begin
            din_s1_ff <= mem_data_in;
            din_s2_ff <= din_s1_ff;
        end
    end
endmodule
`default_nettype wire

//--- verification/apsc_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Pin order checks on the memory side
module apsc_ctrl_checker #(
    parameter CHHN_CYC = 50
) (
    input wire mclk_in,
    input wire srst_in,
    input wire mem_we_n_out,
    input wire mem_oe_n_out,
    input wire mem_data_oe_out,
    input wire [21:0] mem_addr_out,
    input wire upper_byte_lane_n_out,
    input wire lower_byte_lane_n_out,
    input wire byte_config_input_out,
    input wire sram_primary_select_n_out,
    input wire fcram_primary_select_n_out,
    input wire fcram_powerdown_enable_out,
    input wire program_enable_n_out
);
    reg [15:0] hold_ff; // Cycles since power-down exit
    // Starts saturated so the first select after reset is legal
    always @(posedge mclk_in) begin
        if (srst_in) begin
            hold_ff <= 16'hFFFF;
        end else if (!fcram_powerdown_enable_out) begin
            hold_ff <= 16'h0000;
        end else if (hold_ff != 16'hFFFF) begin
            hold_ff <= hold_ff + 16'h0001;
        end
    end
    a_lane_picked_write: assert property (@(posedge mclk_in) disable iff (srst_in)
        !mem_we_n_out |-> !(upper_byte_lane_n_out && lower_byte_lane_n_out)) else $error("write without lane");
    a_config_held_high: assert property (@(posedge mclk_in) disable iff (srst_in)
        byte_config_input_out) else $error("byte config low");
    a_read_pins_high: assert property (@(posedge mclk_in) disable iff (srst_in)
        !mem_oe_n_out |-> mem_we_n_out && program_enable_n_out && fcram_powerdown_enable_out && !mem_data_oe_out)
        else $error("read with bad pins");
    a_write_enables_high: assert property (@(posedge mclk_in) disable iff (srst_in)
        !mem_we_n_out |-> fcram_powerdown_enable_out && program_enable_n_out && mem_data_oe_out)
        else $error("write with bad enables");
    a_strobe_pulse_width: assert property (@(posedge mclk_in) disable iff (srst_in)
        $fell(mem_we_n_out) |-> !mem_we_n_out [*3]) else $error("strobe pulse short");
    a_write_cycle_span: assert property (@(posedge mclk_in) disable iff (srst_in)
        $fell(fcram_primary_select_n_out) |-> !fcram_primary_select_n_out [*4]) else $error("cycle short");
    a_addr_held_write: assert property (@(posedge mclk_in) disable iff (srst_in)
        !mem_we_n_out && !$past(mem_we_n_out) |-> $stable(mem_addr_out)) else $error("address moved");
    a_select_gap_kept: assert property (@(posedge mclk_in) disable iff (srst_in)
        $rose(fcram_primary_select_n_out) |=> fcram_primary_select_n_out) else $error("select gap short");
    a_exit_hold_time: assert property (@(posedge mclk_in) disable iff (srst_in)
        $fell(fcram_primary_select_n_out) |-> hold_ff >= CHHN_CYC - 1) else $error("exit hold short");
    a_prog_pulse_width: assert property (@(posedge mclk_in) disable iff (srst_in)
        $fell(program_enable_n_out) |-> (!program_enable_n_out && fcram_primary_select_n_out) [*4])
        else $error("program pulse bad");
endmodule
bind apsc_ctrl apsc_ctrl_checker #(.CHHN_CYC(CHHN_CYC)) apsc_ctrl_checker_inst (.mclk_in, .srst_in,
    .mem_we_n_out, .mem_oe_n_out, .mem_data_oe_out, .mem_addr_out, .upper_byte_lane_n_out,
    .lower_byte_lane_n_out, .byte_config_input_out, .sram_primary_select_n_out,
    .fcram_primary_select_n_out, .fcram_powerdown_enable_out, .program_enable_n_out);
`default_nettype wire

//--- verification/apsc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Behavioural SRAM and FCRAM dies, 64 words each
module apsc_mem_model (
    input wire [21:0] addr_in,
    input wire [15:0] wdata_in,
    input wire we_n_in,
    input wire oe_n_in,
    input wire ub_n_in,
    input wire lb_n_in,
    input wire cfg_in,
    input wire sram_sel_n_in,
    input wire sram_sel2_in,
    input wire fc_sel_n_in,
    input wire fc_pd_in,
    input wire pe_n_in,
    output logic [15:0] rdata_out
);
    logic [15:0] sram_mem [0:63]; // SRAM die image
    logic [15:0] fc_mem [0:63]; // FCRAM die image
    logic [15:0] wd_q; // Data seen during overlap
    logic [1:0] ln_q; // Lanes seen during overlap
    logic [15:0] junk_q = 16'hA5A5; // Released bus pattern
    wire sram_wr = !sram_sel_n_in && sram_sel2_in && !we_n_in;
    wire fc_wr = !fc_sel_n_in && !we_n_in && fc_pd_in && pe_n_in;
    function automatic logic [15:0] put(input logic [15:0] o, input logic [15:0] n, input logic [1:0] m);
        put = {m[1] ? n[15:8] : o[15:8], m[0] ? n[7:0] : o[7:0]};
    endfunction
    initial begin
        for (int i = 0; i < 64; i++) begin
            sram_mem[i] = 16'h0000;
            fc_mem[i] = 16'h0000;
        end
    end
    // Undriven bus alternates between A5A5 and its inverse
    always #10 junk_q = ~junk_q;
    // Track data and lanes while write overlap lasts
    always @* begin
        if (sram_wr || fc_wr) begin
            wd_q = wdata_in;
            ln_q = cfg_in ? ~{ub_n_in, lb_n_in} : 2'b11;
        end
    end
    // Write lands at first rise of select or strobe
    always @(negedge sram_wr) sram_mem[addr_in[5:0]] = put(sram_mem[addr_in[5:0]], wd_q, ln_q);
    always @(negedge fc_wr) fc_mem[addr_in[5:0]] = put(fc_mem[addr_in[5:0]], wd_q, ln_q);
    // Read drive while output enable low
    always_comb begin
        if (!oe_n_in && we_n_in && !sram_sel_n_in && sram_sel2_in) begin
            rdata_out = sram_mem[addr_in[5:0]];
        end else if (!oe_n_in && we_n_in && !fc_sel_n_in && fc_pd_in) begin
            rdata_out = fc_mem[addr_in[5:0]];
        end else begin
            rdata_out = junk_q;
        end
    end
endmodule
`default_nettype wire

//--- verification/test_apsc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "apsc_regs.vh"
// ========================================
// Random writes, readback, power-down and program
module test_apsc_ctrl;
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic [2:0] req_cmd_in = 3'h0;
    logic [21:0] req_addr_in = 22'h000000;
    logic [15:0] req_wdata_in = 16'h0000;
    logic [1:0] req_byte_en_in = 2'h0;
    logic req_sleep_in = 1'b0;
    wire req_ready_out, rsp_valid_out, mem_data_oe_out, mem_we_n_out, mem_oe_n_out;
    wire upper_byte_lane_n_out, lower_byte_lane_n_out, byte_config_input_out, sram_primary_select_n_out;
    wire sram_secondary_select_out, fcram_primary_select_n_out, fcram_powerdown_enable_out, program_enable_n_out;
    wire [15:0] rsp_rdata_out, mem_data_out, mem_data_in;
    wire [21:0] mem_addr_out;
    int num_errors = 0;
    int num_checks = 0;
    int cyc; // Cycles from take to response
    logic [15:0] sram_exp [0:63];
    logic [15:0] fc_exp [0:63];
    // Short hold counts keep the run brief
    apsc_ctrl #(.CHH_CYC(20), .CHHN_CYC(5)) apsc_ctrl_inst (.mclk_in, .srst_in, .req_valid_in, .req_ready_out,
        .req_cmd_in, .req_addr_in, .req_wdata_in, .req_byte_en_in, .req_sleep_in, .rsp_valid_out, .rsp_rdata_out,
        .mem_addr_out, .mem_data_in, .mem_data_out, .mem_data_oe_out, .mem_we_n_out, .mem_oe_n_out,
        .upper_byte_lane_n_out, .lower_byte_lane_n_out, .byte_config_input_out, .sram_primary_select_n_out,
        .sram_secondary_select_out, .fcram_primary_select_n_out, .fcram_powerdown_enable_out, .program_enable_n_out);
    apsc_mem_model apsc_mem_model_inst (.addr_in(mem_addr_out),
        .wdata_in(mem_data_oe_out ? mem_data_out : ~mem_data_out), .we_n_in(mem_we_n_out),
        .oe_n_in(mem_oe_n_out), .ub_n_in(upper_byte_lane_n_out), .lb_n_in(lower_byte_lane_n_out),
        .cfg_in(byte_config_input_out), .sram_sel_n_in(sram_primary_select_n_out),
        .sram_sel2_in(sram_secondary_select_out), .fc_sel_n_in(fcram_primary_select_n_out),
        .fc_pd_in(fcram_powerdown_enable_out), .pe_n_in(program_enable_n_out), .rdata_out(mem_data_in));
    initial forever #10 mclk_in = ~mclk_in;
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] be);
        logic [1:0] m;
        m = (be == 2'b00) ? 2'b11 : be;
        merge = {m[1] ? n[15:8] : o[15:8], m[0] ? n[7:0] : o[7:0]};
    endfunction
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Hold request until taken, then wait bounded for response when want is set
    task automatic do_req(input logic [2:0] cmd, input logic [21:0] adr, input logic [15:0] wd,
                          input logic [1:0] be, input logic slp, input logic want);
        int n;
        req_cmd_in = cmd;
        req_addr_in = adr;
        req_wdata_in = wd;
        req_byte_en_in = be;
        req_sleep_in = slp;
        req_valid_in = 1'b1;
        n = 0;
        cyc = 0;
        @(posedge mclk_in);
        while (req_ready_out !== 1'b1) begin
            n++;
            if (n > 5000) begin
                check("ready", 16'h0001, 16'h0000);
                summarize();
            end
            @(posedge mclk_in);
        end
        #1 req_valid_in = 1'b0;
        if (!want) begin
            // Lets an edge pass so valid is not raised again in this step
            @(posedge mclk_in);
            #1;
        end
        while (want && rsp_valid_out !== 1'b1) begin
            cyc++;
            if (cyc > 5000) begin
                check("response", 16'h0001, 16'h0000);
                summarize();
            end
            @(posedge mclk_in);
            #1;
        end
    endtask
    initial begin
        void'($urandom(26337));
        for (int i = 0; i < 64; i++) begin
            sram_exp[i] = 16'h0000;
            fc_exp[i] = 16'h0000;
        end
        repeat (2) @(posedge mclk_in);
        #1 srst_in = 1'b0;
        check("idle pins", 16'h03FE, {6'h00, sram_secondary_select_out, mem_we_n_out, mem_oe_n_out,
            upper_byte_lane_n_out,
            lower_byte_lane_n_out, sram_primary_select_n_out, fcram_primary_select_n_out,
            fcram_powerdown_enable_out, program_enable_n_out, mem_data_oe_out});
        // Single lanes back to back on top word first, then random
        for (int i = 0; i < 40; i++) begin
            logic sel;
            logic [5:0] a;
            logic [15:0] d;
            logic [1:0] be;
            sel = (i < 4) ? i[0] : 1'($urandom);
            a = (i < 4) ? 6'h3F : 6'($urandom);
            be = (i < 4) ? (i[1] ? 2'b10 : 2'b01) : 2'($urandom);
            d = 16'($urandom);
            do_req(sel ? `APSC_CMD_FC_WR : `APSC_CMD_SRAM_WR, {16'h0000, a}, d, be, 1'b0, 1'b1);
            if (sel) fc_exp[a] = merge(fc_exp[a], d, be);
            else sram_exp[a] = merge(sram_exp[a], d, be);
        end
        for (int i = 0; i < 128; i++) begin
            do_req(i[6] ? `APSC_CMD_FC_RD : `APSC_CMD_SRAM_RD, {16'h0000, i[5:0]}, 16'h0000, 2'b00, 1'b0, 1'b1);
            check("read word", i[6] ? fc_exp[i[5:0]] : sram_exp[i[5:0]], rsp_rdata_out);
        end
        // Power-down with and without sleep
        for (int s = 0; s < 2; s++) begin
            do_req(`APSC_CMD_PD_ENTER, 22'h000000, 16'h0000, 2'b00, 1'b0, 1'b0);
            do_req(`APSC_CMD_PD_EXIT, 22'h000000, 16'h0000, 2'b00, s[0], 1'b1);
            check("exit hold", 16'h0001, {15'h0000, cyc >= (s ? 20 : 5)});
        end
        do_req(`APSC_CMD_PD_PROG, 22'($urandom), 16'h0000, 2'b00, 1'b0, 1'b1);
        // Setup, pulse and hold each span at least the program pulse minimum
        check("program time", 16'h0001, {15'h0000, cyc >= 3 * `APSC_CYC(`APSC_T_EP_NS)});
        do_req(`APSC_CMD_FC_WR, 22'h000005, 16'hC3A5, 2'b00, 1'b0, 1'b1);
        do_req(`APSC_CMD_FC_RD, 22'h000005, 16'h0000, 2'b00, 1'b0, 1'b1);
        check("word after exit", 16'hC3A5, rsp_rdata_out);
        summarize();
    end
endmodule
`default_nettype wire
